// ---- hdl/psf_pkg.sv ----
// Purpose: Constants and types for the processor status flags block.
// Assumes: Avalon-MM slave with 32-bit data, one word per register.
// Notes on behaviour
// - Direct bank select one maps direct accesses to addresses 80h through FFh.
// - Direct bank select zero maps direct accesses to addresses 00h through 7Fh.
// - Each bank spans 128 bytes, indexed by the 7-bit instruction field.
// - Time-out flag sets at power-up, watchdog clear and low-power halt.
// - Time-out flag clears when the watchdog timer expires.
// - Power-down flag sets at power-up and on watchdog clear.
// - Power-down flag clears on the low-power halt instruction.
// - Zero flag follows whether the result equals zero, for affecting instructions.
// - Digit-carry flag is the carry out of the fourth low-order bit.
// - Carry flag is the carry out of the most significant bit.
// - Subtraction adds the two's complement; carries act as inverted borrows.
// - Computed flags override written ones; reset-cause flags ignore writes.
`default_nettype none
package psf_pkg;
    localparam logic [7:0] PSF_FLAGS_OFS = 8'h03;
    localparam logic [7:0] PSF_FLAGS_MIRROR_OFS = 8'h83;
    localparam logic [7:0] PSF_BANK_SIZE = 8'h80;
    localparam logic [7:0] PSF_IRQ_STAT_OFS = 8'hF0;
    localparam logic [7:0] PSF_IRQ_MASK_OFS = 8'hF1;
    localparam logic [7:0] PSF_DADDR_OFS = 8'hF2;
    localparam int PSF_BIT_C = 0;
    localparam int PSF_BIT_DC = 1;
    localparam int PSF_BIT_Z = 2;
    localparam int PSF_BIT_PD = 3;
    localparam int PSF_BIT_TO = 4;
    localparam int PSF_BIT_LO = 5;
    localparam int PSF_BIT_HI = 6;
    localparam int PSF_BIT_IRP = 7;
    localparam logic [7:0] PSF_FLAGS_RST = 8'h18;
    localparam logic [7:0] PSF_WR_MASK = 8'hE7;
    localparam int PSF_EV_WDT = 0;
    localparam int PSF_EV_HALT = 1;
    localparam int PSF_EV_CLR = 2;
    localparam logic [2:0] PSF_EV_RST = 3'h0;
    typedef enum logic [1:0] {
        PSF_OP_NONE = 2'b00,
        PSF_OP_ADD = 2'b01,
        PSF_OP_SUB = 2'b10,
        PSF_OP_LOGIC = 2'b11
    } psf_op_t;
    typedef struct packed {
        psf_op_t op;
        logic [7:0] a;
        logic [7:0] b;
    } psf_alu_req_t;
    typedef struct packed {
        logic [7:0] result;
        logic z;
        logic dc;
        logic c;
    } psf_alu_res_t;
endpackage
`default_nettype wire

// ---- hdl/psf_alu_flags.sv ----
// Purpose: Computes result and arithmetic flags of one ALU operation.
// Assumes: Operands are stable in the cycle of use.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module psf_alu_flags (
    input wire psf_pkg::psf_alu_req_t req_i,
    output var psf_pkg::psf_alu_res_t res_o
);
    logic [7:0] opnd_b;
    logic [8:0] sum;
    logic [4:0] low_sum;
    always_comb begin
        // Subtract by adding the complement plus one, so carries are inverted borrows.
        opnd_b = (req_i.op == psf_pkg::PSF_OP_SUB) ? ~req_i.b : req_i.b;
        sum = {1'b0, req_i.a} + {1'b0, opnd_b} + {8'h00, req_i.op == psf_pkg::PSF_OP_SUB};
        low_sum = {1'b0, req_i.a[3:0]} + {1'b0, opnd_b[3:0]}
            + {4'h0, req_i.op == psf_pkg::PSF_OP_SUB};
        res_o.result = (req_i.op == psf_pkg::PSF_OP_LOGIC) ? req_i.b : sum[7:0];
        res_o.z = (res_o.result == 8'h00);
        res_o.dc = low_sum[4];
        res_o.c = sum[8];
    end
endmodule
`default_nettype wire

// ---- hdl/psf_status_reg.sv ----
// Purpose: Processor status flags register with bank decode and events.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Registers reached over Avalon-MM; answers with one wait state.
`timescale 1ns/1ps
`default_nettype none
module psf_status_reg (
    input wire logic MCLK_I,
    input wire logic SRST_I,
    input wire logic [7:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    output logic [1:0] AVS_RESPONSE_O,
    input wire psf_pkg::psf_alu_req_t ALU_REQ_I,
    input wire logic ALU_WR_FLAGS_I,
    input wire logic [6:0] REG_FIELD_I,
    input wire logic WATCHDOG_CLEAR_INSTR_I,
    input wire logic HALT_INSTR_I,
    input wire logic WATCHDOG_TIMER_EXPIRED_I,
    output logic [7:0] DIRECT_ADDR_O,
    output logic [7:0] ALU_RESULT_O,
    output logic IRQ_O
);
    // ------------------------------------------------------------
    // Flags and event state
    // ------------------------------------------------------------
    psf_pkg::psf_alu_res_t alu_res;
    logic [7:0] flags_r, flags_nxt;
    logic [2:0] ev_stat_r, ev_stat_nxt;
    logic [2:0] ev_mask_r, ev_mask_nxt;
    logic [7:0] daddr_r, daddr_nxt;
    logic [7:0] res_r, res_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] resp_r, resp_nxt;
    logic [7:0] wmask;
    logic hit_flags, hit_stat, hit_mask, hit_daddr, req, wr_now, rd_now;
    logic [2:0] ev_in;

    psf_alu_flags psf_alu_flags_inst (
        .req_i(ALU_REQ_I),
        .res_o(alu_res)
    );

    always_comb begin
        req = (AVS_READ_I | AVS_WRITE_I) & ~ack_r;
        wr_now = AVS_WRITE_I & ack_r;
        rd_now = AVS_READ_I & ~ack_r;
        // Same physical register in both banks.
        hit_flags = (AVS_ADDRESS_I == psf_pkg::PSF_FLAGS_OFS)
            | (AVS_ADDRESS_I == psf_pkg::PSF_FLAGS_MIRROR_OFS);
        hit_stat = AVS_ADDRESS_I == psf_pkg::PSF_IRQ_STAT_OFS;
        hit_mask = AVS_ADDRESS_I == psf_pkg::PSF_IRQ_MASK_OFS;
        hit_daddr = AVS_ADDRESS_I == psf_pkg::PSF_DADDR_OFS;
        wmask = AVS_BYTEENABLE_I[0] ? psf_pkg::PSF_WR_MASK : 8'h00;
        ev_in = 3'h0;
        ev_in[psf_pkg::PSF_EV_WDT] = WATCHDOG_TIMER_EXPIRED_I;
        ev_in[psf_pkg::PSF_EV_HALT] = HALT_INSTR_I;
        ev_in[psf_pkg::PSF_EV_CLR] = WATCHDOG_CLEAR_INSTR_I;
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        flags_nxt = flags_r;
        if (wr_now && hit_flags) begin
            // Reset-cause flags are never written by software.
            flags_nxt = (flags_r & ~wmask) | (AVS_WRITEDATA_I[7:0] & wmask);
        end
        if (ALU_WR_FLAGS_I) begin
            // Computed flags win over a same-cycle software write.
            flags_nxt[psf_pkg::PSF_BIT_Z] = alu_res.z;
            if (ALU_REQ_I.op == psf_pkg::PSF_OP_ADD || ALU_REQ_I.op == psf_pkg::PSF_OP_SUB) begin
                flags_nxt[psf_pkg::PSF_BIT_DC] = alu_res.dc;
                flags_nxt[psf_pkg::PSF_BIT_C] = alu_res.c;
            end
        end
        if (WATCHDOG_CLEAR_INSTR_I) begin
            flags_nxt[psf_pkg::PSF_BIT_TO] = 1'b1;
            flags_nxt[psf_pkg::PSF_BIT_PD] = 1'b1;
        end
        if (HALT_INSTR_I) begin
            flags_nxt[psf_pkg::PSF_BIT_TO] = 1'b1;
            flags_nxt[psf_pkg::PSF_BIT_PD] = 1'b0;
        end
        // An expiry is the latest cause and so takes precedence.
        if (WATCHDOG_TIMER_EXPIRED_I) begin
            flags_nxt[psf_pkg::PSF_BIT_TO] = 1'b0;
        end

        // The event set wins over a write-one clear in the same cycle.
        ev_stat_nxt = ev_stat_r;
        if (wr_now && hit_stat && AVS_BYTEENABLE_I[0]) begin
            ev_stat_nxt = ev_stat_r & ~AVS_WRITEDATA_I[2:0];
        end
        ev_stat_nxt = ev_stat_nxt | ev_in;
        ev_mask_nxt = ev_mask_r;
        if (wr_now && hit_mask && AVS_BYTEENABLE_I[0]) begin
            ev_mask_nxt = AVS_WRITEDATA_I[2:0];
        end

        // Direct address: bank bit above the 7-bit field. Upper bank bit is left out
        // because software keeps it clear on this device.
        daddr_nxt = {flags_r[psf_pkg::PSF_BIT_LO], REG_FIELD_I};
        res_nxt = ALU_WR_FLAGS_I ? alu_res.result : res_r;

        // Bus: first cycle holds waitrequest, second cycle completes.
        ack_nxt = req;
        rdata_nxt = rdata_r;
        resp_nxt = resp_r;
        if (req) begin
            resp_nxt = (hit_flags | hit_stat | hit_mask | hit_daddr) ? 2'h0 : 2'h2;
            rdata_nxt = 32'h0000_0000;
            if (rd_now) begin
                if (hit_flags) begin
                    rdata_nxt = {24'h00_0000, flags_r};
                end else if (hit_stat) begin
                    rdata_nxt = {29'h0000_0000, ev_stat_r};
                end else if (hit_mask) begin
                    rdata_nxt = {29'h0000_0000, ev_mask_r};
                end else if (hit_daddr) begin
                    rdata_nxt = {24'h00_0000, daddr_r};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            flags_r <= psf_pkg::PSF_FLAGS_RST;
            ev_stat_r <= psf_pkg::PSF_EV_RST;
            ev_mask_r <= psf_pkg::PSF_EV_RST;
            daddr_r <= 8'h00;
            res_r <= 8'h00;
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            resp_r <= 2'h0;
        end else begin
            flags_r <= flags_nxt;
            ev_stat_r <= ev_stat_nxt;
            ev_mask_r <= ev_mask_nxt;
            daddr_r <= daddr_nxt;
            res_r <= res_nxt;
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
            resp_r <= resp_nxt;
        end
    end

    assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_r;
    assign AVS_READDATA_O = rdata_r;
    assign AVS_RESPONSE_O = resp_r;
    assign DIRECT_ADDR_O = daddr_r;
    assign ALU_RESULT_O = res_r;
    assign IRQ_O = |(ev_stat_r & ev_mask_r);
endmodule
`default_nettype wire

// ---- test/psf_status_reg_monitor.sv ----
// Purpose: Port-level checks of the status flags block.
// Assumes: One clock; the master holds a request until waitrequest falls.
// Notes: The bank bit may show up to two edges after its write completes.
`timescale 1ns/1ps
`default_nettype none
module psf_monitor (
    input wire logic MCLK_I,
    input wire logic SRST_I,
    input wire logic [7:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic AVS_WAITREQUEST_O,
    input wire logic [1:0] AVS_RESPONSE_O,
    input wire logic [6:0] REG_FIELD_I,
    input wire logic [7:0] DIRECT_ADDR_O
);
    logic req, done, fl, map;
    assign req = AVS_READ_I | AVS_WRITE_I;
    assign done = req & ~AVS_WAITREQUEST_O;
    assign fl = AVS_ADDRESS_I[6:0] == 7'h03;
    assign map = fl | (AVS_ADDRESS_I >= 8'hF0 && AVS_ADDRESS_I <= 8'hF2);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (SRST_I);
    a_wait_first: assert property ($rose(req) |-> AVS_WAITREQUEST_O)
        else $error("request not held off in its first cycle");
    a_wait_one: assert property (req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("more than one wait state");
    a_resp_bad: assert property (done && !map |-> AVS_RESPONSE_O == 2'h2)
        else $error("unmapped access not refused");
    a_resp_ok: assert property (done && map |-> AVS_RESPONSE_O == 2'h0)
        else $error("mapped access refused");
    a_rdata_zero: assert property (done && AVS_READ_I && !map
        |-> AVS_READDATA_O == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_field_pass: assert property (!$past(SRST_I)
        |-> DIRECT_ADDR_O[6:0] == $past(REG_FIELD_I))
        else $error("bank offset not the instruction field");
    a_bank_follow: assert property (done && AVS_WRITE_I && fl && AVS_BYTEENABLE_I[0]
        |-> ##2 DIRECT_ADDR_O[7] == $past(AVS_WRITEDATA_I[5], 2))
        else $error("bank bit does not follow write");
    a_bank_change: assert property (!$past(SRST_I) && !$past(SRST_I, 2)
        && $changed(DIRECT_ADDR_O[7])
        |-> $past(done && AVS_WRITE_I) || $past(done && AVS_WRITE_I, 2))
        else $error("bank bit moved without a write");
    cover property (done && !map);
    cover property (done && AVS_WRITE_I && fl);
    cover property ($rose(DIRECT_ADDR_O[7]));
endmodule
bind psf_status_reg psf_monitor psf_monitor_inst (.MCLK_I(MCLK_I), .SRST_I(SRST_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .AVS_RESPONSE_O(AVS_RESPONSE_O), .REG_FIELD_I(REG_FIELD_I), .DIRECT_ADDR_O(DIRECT_ADDR_O));
`default_nettype wire

// ---- test/psf_status_reg_tb.sv ----
// Purpose: Self-checking bench of the status flags block.
// Assumes: One wait state per access; inputs change at rising edges.
// Notes: Bus answers and the ALU result are taken at the rising edge; other outputs at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module psf_status_reg_tb;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, q;
    logic wq, irq;
    logic [1:0] resp;
    psf_pkg::psf_alu_req_t alu_req = '0;
    logic alu_wr = 1'b0;
    logic [6:0] field = 7'h00;
    logic [2:0] ev = 3'h0;
    logic [7:0] daddr, alu_res;
    int n_fail = 0;
    int samples_checked = 0;
    psf_status_reg psf_status_reg_inst (.MCLK_I(mclk), .SRST_I(srst), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hF),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wq), .AVS_RESPONSE_O(resp),
        .ALU_REQ_I(alu_req), .ALU_WR_FLAGS_I(alu_wr), .REG_FIELD_I(field),
        .WATCHDOG_CLEAR_INSTR_I(ev[2]), .HALT_INSTR_I(ev[1]), .WATCHDOG_TIMER_EXPIRED_I(ev[0]),
        .DIRECT_ADDR_O(daddr), .ALU_RESULT_O(alu_res), .IRQ_O(irq));
    initial forever #10 mclk = ~mclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= {24'h0, d};
        // Answer and read data are taken at the rising edge, before it updates them.
        do @(posedge mclk); while (wq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, {24'h0, e});
    endtask
    task automatic t_reset;
        rdchk(8'h03, 8'h18);
        rdchk(8'h83, 8'h18);
        rdchk(8'h10, 8'h00);
        chk({30'h0, resp}, 32'h2);
        $display("test reset done");
    endtask
    task automatic t_bank;
        field <= 7'h7F;
        bus(1'b1, 8'h83, 8'h27);
        rdchk(8'h03, 8'h3F);
        repeat (2) @(negedge mclk);
        chk({24'h0, daddr}, 32'hFF);
        bus(1'b1, 8'h03, 8'h00);
        rdchk(8'h03, 8'h18);
        repeat (2) @(negedge mclk);
        chk({24'h0, daddr}, 32'h7F);
        @(posedge mclk);
        field <= 7'h55;
        repeat (2) @(negedge mclk);
        chk({24'h0, daddr}, 32'h55);
        rdchk(8'hF2, 8'h55);
        $display("test bank done");
    endtask
    task automatic t_alu;
        logic [7:0] a [5] = '{8'h0F, 8'hFF, 8'h05, 8'h00, 8'h00};
        logic [7:0] b [5] = '{8'h01, 8'h01, 8'h05, 8'h01, 8'h00};
        logic [1:0] o [5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] bb;
        logic [2:0] e;
        e = 3'h0;
        for (int i = 0; i < 5; i++) begin
            bb = (o[i] == 2'h2) ? ~b[i] : b[i];
            s = a[i] + bb + (o[i] == 2'h2);
            h = a[i][3:0] + bb[3:0] + (o[i] == 2'h2);
            if (o[i] == 2'h3) s = {1'b0, b[i]};
            e = (o[i] == 2'h3) ? {s[7:0] == 8'h0, e[1:0]} : {s[7:0] == 8'h0, h[4], s[8]};
            @(posedge mclk);
            alu_req <= '{psf_pkg::psf_op_t'(o[i]), a[i], b[i]};
            alu_wr <= 1'b1;
            @(posedge mclk);
            alu_wr <= 1'b0;
            rdchk(8'h03, {5'h03, e});
            chk({24'h0, alu_res}, {24'h0, s[7:0]});
        end
        // The computed flags must beat a bus write that completes on the same edge.
        fork
            bus(1'b1, 8'h03, 8'h03);
            begin
                repeat (2) @(posedge mclk);
                alu_req <= '{psf_pkg::PSF_OP_ADD, 8'h00, 8'h00};
                alu_wr <= 1'b1;
                @(posedge mclk);
                alu_wr <= 1'b0;
            end
        join
        rdchk(8'h03, 8'h1C);
        $display("test alu done");
    endtask
    task automatic t_event;
        int k [3] = '{1, 0, 2};
        logic [1:0] e [3] = '{2'b10, 2'b00, 2'b11};
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            ev <= 3'h1 << k[i];
            @(posedge mclk);
            ev <= 3'h0;
            rdchk(8'h03, {3'h0, e[i], 3'h4});
        end
        rdchk(8'hF0, 8'h07);
        bus(1'b1, 8'hF1, 8'h02);
        repeat (2) @(negedge mclk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, 8'hF0, 8'h02);
        repeat (2) @(negedge mclk);
        chk({31'h0, irq}, 32'h0);
        rdchk(8'hF0, 8'h05);
        // An event on the edge that completes a write-one clear keeps its bit set.
        fork
            bus(1'b1, 8'hF0, 8'h05);
            begin
                repeat (2) @(posedge mclk);
                ev <= 3'h1;
                @(posedge mclk);
                ev <= 3'h0;
            end
        join
        rdchk(8'hF0, 8'h01);
        rdchk(8'h03, 8'h0C);
        $display("test event done");
    endtask
    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        t_reset;
        t_bank;
        t_alu;
        t_event;
        stop_test;
    end
    // A stuck handshake would hang the bus task, so the run is cut off here.
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        stop_test;
    end
endmodule
`default_nettype wire
